// *** logic/exception_vector_table.sv ***
// vector number to table slot, priority and source mapping for the nested interrupt controller
module exception_vector_table
  import vector_table_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             fetchReq,
  input  wire logic [VEC_W-1:0] fetchVec,
  input  wire baseWr_s          baseWr,
  input  wire prioWr_s          prioWr,
  input  wire nmiSrc_s          nmiSrc,
  input  wire busErr_s          busErr,
  output      vecAnswer_s       ans_q,
  output      logic             bootBusy_q,
  output      logic [ADDR_W-1:0] vecBase_q,
  output      logic             baseWrErr_q,
  output      logic             nmiReq_q,
  output      nmiSrc_s          nmiCause_q,
  output      logic             busFaultReq_q,
  output      logic             busFaultPrecise_q
);

  typedef enum logic [1:0] {BOOT_STACK, BOOT_RESET, RUN} boot_e;

  boot_e             state_q;
  boot_e             state_d;
  logic              bootBusy_d;
  logic              reqGo;
  logic [VEC_W-1:0]  reqVec;
  logic              s1Valid_q;
  logic              s1Valid_d;
  logic [VEC_W-1:0]  s1Vec_q;
  logic [VEC_W-1:0]  s1Vec_d;
  logic [PRIO_W-1:0] prioRd;
  vecAnswer_s        ans_d;
  logic [ADDR_W-1:0] vecBase_d;
  logic              baseWrErr_d;
  logic              baseOk;
  logic              nmiReq_d;
  logic              busFaultReq_d;
  logic              busFaultPrecise_d;

  // ----------------------------------------------------------------
  // boot sequencing and request select
  // ----------------------------------------------------------------
  // core lookups wait until the stack and reset slots have been served
  always_comb begin
    state_d = state_q;
    reqGo   = 1'b0;
    reqVec  = fetchVec;
    unique case (state_q)
      BOOT_STACK: begin
        reqGo   = 1'b1;
        reqVec  = VEC_STACK;
        state_d = BOOT_RESET;
      end
      BOOT_RESET: begin
        reqGo   = 1'b1;
        reqVec  = VEC_RESET;
        state_d = RUN;
      end
      RUN: begin
        reqGo = fetchReq;
      end
    endcase
    bootBusy_d = state_d != RUN;
    s1Valid_d  = reqGo;
    s1Vec_d    = reqVec;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= BOOT_STACK;
      bootBusy_q <= 1'b1;
      s1Valid_q  <= 1'b0;
      s1Vec_q    <= VEC_STACK;
    end else begin
      state_q    <= state_d;
      bootBusy_q <= bootBusy_d;
      s1Valid_q  <= s1Valid_d;
      s1Vec_q    <= s1Vec_d;
    end
  end

  // ----------------------------------------------------------------
  // programmable priority levels
  // ----------------------------------------------------------------
  // writes to fixed or reserved vectors are dropped, not stored
  priority_store u_prio (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wrEn     (prioWr.en && isProgrammable(prioWr.vec)),
    .wrAddr   (prioWr.vec),
    .wrData   (prioWr.level),
    .rdAddr   (reqVec),
    .rdData_q (prioRd)
  );

  // ----------------------------------------------------------------
  // answer stage
  // ----------------------------------------------------------------
  // slot address uses the base live at answer time, so a relocation
  // lands on the very next answer
  always_comb begin
    ans_d          = '0;
    ans_d.valid    = s1Valid_q;
    ans_d.vec      = s1Vec_q;
    ans_d.addr     = slotAddr(vecBase_q, s1Vec_q);
    ans_d.reserved = isReserved(s1Vec_q);
    ans_d.fixed    = 1'b0;
    ans_d.prio     = {1'b0, prioRd};
    unique case (s1Vec_q)
      VEC_RESET: begin
        ans_d.fixed = 1'b1;
        ans_d.prio  = PRIO_FIX_RESET;
      end
      VEC_NMI: begin
        ans_d.fixed = 1'b1;
        ans_d.prio  = PRIO_FIX_NMI;
      end
      VEC_HARDFAULT: begin
        ans_d.fixed = 1'b1;
        ans_d.prio  = PRIO_FIX_HARD;
      end
      default: begin
        if (!isProgrammable(s1Vec_q)) begin
          ans_d.prio = '0; // stack slot and reserved carry no level
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ans_q <= '0;
    end else begin
      ans_q <= ans_d;
    end
  end

  // ----------------------------------------------------------------
  // table base relocation
  // ----------------------------------------------------------------
  // a bad write leaves the base alone; misalignment is refused rather
  // than silently truncated so software sees its mistake
  always_comb begin
    baseOk = baseWr.priv
             && baseWr.base >= BASE_MIN && baseWr.base <= BASE_MAX
             && baseWr.base[BASE_ALIGN_LG-1:0] == '0;
    vecBase_d   = vecBase_q;
    baseWrErr_d = 1'b0;
    if (baseWr.en) begin
      if (baseOk) begin
        vecBase_d = baseWr.base;
      end else begin
        baseWrErr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vecBase_q   <= BASE_RESET;
      baseWrErr_q <= 1'b0;
    end else begin
      vecBase_q   <= vecBase_d;
      baseWrErr_q <= baseWrErr_d;
    end
  end

  // ----------------------------------------------------------------
  // non-maskable and bus fault sources
  // ----------------------------------------------------------------
  // levels pass through one register; the core sees them as async events
  always_comb begin
    nmiReq_d          = |nmiSrc;
    busFaultReq_d     = busErr.memAccessErr || busErr.ramUncorrErr
                        || busErr.flashUncorrErr;
    busFaultPrecise_d = busFaultReq_d && busErr.precise;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmiReq_q          <= 1'b0;
      nmiCause_q        <= '0;
      busFaultReq_q     <= 1'b0;
      busFaultPrecise_q <= 1'b0;
    end else begin
      nmiReq_q          <= nmiReq_d;
      nmiCause_q        <= nmiSrc;
      busFaultReq_q     <= busFaultReq_d;
      busFaultPrecise_q <= busFaultPrecise_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence stackAns;
    ans_q.valid && ans_q.vec == VEC_STACK && ans_q.addr == BASE_RESET;
  endsequence

  sequence resetAns;
    ans_q.valid && ans_q.vec == VEC_RESET && ans_q.prio == PRIO_FIX_RESET;
  endsequence

  a_boot_order: assert property (
    $fell(sys_rst) |-> ##2 stackAns ##1 resetAns)
    else $error("boot did not serve stack slot then reset slot");

  a_boot_busy: assert property (
    $fell(sys_rst) |-> bootBusy_q [*2] ##1 !bootBusy_q)
    else $error("boot busy window wrong length");

  a_base_reset: assert property (
    disable iff (1'b0) sys_rst |=> vecBase_q == BASE_RESET)
    else $error("table base not zero after reset");

  a_base_legal: assert property (
    !$stable(vecBase_q) |-> $past(baseWr.en) && $past(baseWr.priv)
      && vecBase_q >= BASE_MIN && vecBase_q <= BASE_MAX
      && vecBase_q[BASE_ALIGN_LG-1:0] == '0)
    else $error("table base moved without a legal privileged write");

  a_base_refuse: assert property (
    baseWr.en && !baseWr.priv |=> baseWrErr_q && $stable(vecBase_q))
    else $error("unprivileged relocation not refused");

  a_slot_addr: assert property (
    s1Valid_q && !baseWr.en |=> ans_q.valid
      && ans_q.addr == vecBase_q + {ans_q.vec, 2'b00})
    else $error("slot address not base plus four times vector");

  a_irq_slot: assert property (
    ans_q.valid && ans_q.vec == VEC_IRQ_FIRST
      |-> ans_q.addr - vecBase_q == IRQ_SLOT_OFS)
    else $error("first peripheral slot not at 0x40");

  a_reserved_vec: assert property (
    s1Valid_q && (s1Vec_q == VEC_RSV_SOLO || s1Vec_q == VEC_RSV_LO)
      |=> ans_q.reserved && ans_q.prio == '0)
    else $error("reserved vector not flagged");

  a_nmi_fixed: assert property (
    ans_q.valid && ans_q.vec == VEC_NMI |-> ans_q.fixed && ans_q.prio == PRIO_FIX_NMI)
    else $error("nmi priority not fixed at -2");

  a_nmi_sources: assert property (
    nmiSrc != '0 |=> nmiReq_q && nmiCause_q == $past(nmiSrc))
    else $error("nmi source did not raise nmi");

  a_bus_fault: assert property (
    busErr.ramUncorrErr || busErr.flashUncorrErr
      |=> busFaultReq_q && busFaultPrecise_q == $past(busErr.precise))
    else $error("uncorrectable error did not raise bus fault");

endmodule // exception_vector_table

// *** logic/vector_table_pkg.sv ***
// constants, types and helpers shared by the exception vector table logic
package vector_table_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int VEC_W  = 7;   // vector numbers 0..127, table ends at 107
  localparam int PRIO_W = 8;   // programmable priority level width
  localparam int ADDR_W = 32;
  localparam int FPRI_W = PRIO_W + 1; // signed priority, fixed levels negative
  localparam int PRIO_DEPTH = 128;

  // ----------------------------------------------------------------
  // vector numbers
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VEC_STACK     = 7'h00;
  localparam logic [VEC_W-1:0] VEC_RESET     = 7'h01;
  localparam logic [VEC_W-1:0] VEC_NMI       = 7'h02;
  localparam logic [VEC_W-1:0] VEC_HARDFAULT = 7'h03;
  localparam logic [VEC_W-1:0] VEC_BUSFAULT  = 7'h05;
  localparam logic [VEC_W-1:0] VEC_RSV_LO    = 7'h07;
  localparam logic [VEC_W-1:0] VEC_RSV_HI    = 7'h0a;
  localparam logic [VEC_W-1:0] VEC_RSV_SOLO  = 7'h0d;
  localparam logic [VEC_W-1:0] VEC_IRQ_FIRST = 7'h10; // 16
  localparam logic [VEC_W-1:0] VEC_LAST      = 7'h6b; // 107

  // ----------------------------------------------------------------
  // table base, offsets and relocation limits
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BASE_RESET    = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] BASE_MIN      = 32'h0000_0200;
  localparam logic [ADDR_W-1:0] BASE_MAX      = 32'h3fff_fe00;
  localparam int                BASE_ALIGN_LG = 9;   // 512-byte boundary
  localparam logic [ADDR_W-1:0] IRQ_SLOT_OFS  = 32'h0000_0040;
  localparam int                SLOT_LG       = 2;   // 4 bytes per slot

  // ----------------------------------------------------------------
  // priorities
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] PRIO_RESET     = 8'h00;
  localparam logic [FPRI_W-1:0] PRIO_FIX_RESET = 9'h1fd; // -3
  localparam logic [FPRI_W-1:0] PRIO_FIX_NMI   = 9'h1fe; // -2
  localparam logic [FPRI_W-1:0] PRIO_FIX_HARD  = 9'h1ff; // -1

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              en;
    logic              priv;
    logic [ADDR_W-1:0] base;
  } baseWr_s;

  typedef struct packed {
    logic              en;
    logic [VEC_W-1:0]  vec;
    logic [PRIO_W-1:0] level;
  } prioWr_s;

  typedef struct packed {
    logic              valid;
    logic [VEC_W-1:0]  vec;
    logic [ADDR_W-1:0] addr;
    logic [FPRI_W-1:0] prio;
    logic              fixed;
    logic              reserved;
  } vecAnswer_s;

  typedef struct packed {
    logic clockFail;
    logic control_irq_expansion_error;
    logic external_nonmaskable_input;
    logic control_nonmaskable_watchdog;
  } nmiSrc_s;

  typedef struct packed {
    logic memAccessErr;
    logic ramUncorrErr;
    logic flashUncorrErr;
    logic precise;
  } busErr_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // reserved slots and anything past the end of the table
  function automatic logic isReserved(input logic [VEC_W-1:0] vec);
    return (vec >= VEC_RSV_LO && vec <= VEC_RSV_HI) || vec == VEC_RSV_SOLO
           || vec > VEC_LAST;
  endfunction

  // vectors 0..3 (stack slot and fixed levels) and reserved slots keep no level; everything else in the table is programmable
  function automatic logic isProgrammable(input logic [VEC_W-1:0] vec);
    return vec > VEC_HARDFAULT && !isReserved(vec);
  endfunction

  // slot address from the current base; irq 16 lands on base + 0x40
  function automatic logic [ADDR_W-1:0] slotAddr(input logic [ADDR_W-1:0] base,
                                                 input logic [VEC_W-1:0]  vec);
    logic [ADDR_W-1:0] ofs;
    ofs = {{(ADDR_W-VEC_W-SLOT_LG){1'b0}}, vec, {SLOT_LG{1'b0}}};
    return base + ofs;
  endfunction

endpackage : vector_table_pkg

// *** logic/priority_store.sv ***
// priority level memory for programmable exceptions and interrupts
module priority_store
  import vector_table_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              wrEn,
  input  wire logic [VEC_W-1:0]  wrAddr,
  input  wire logic [PRIO_W-1:0] wrData,
  input  wire logic [VEC_W-1:0]  rdAddr,
  output      logic [PRIO_W-1:0] rdData_q
);

  logic [PRIO_W-1:0] mem_q [PRIO_DEPTH];
  logic [PRIO_W-1:0] rdData_d;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // write-first so a level written this cycle is seen by a same-cycle lookup
  always_comb begin
    rdData_d = mem_q[rdAddr];
    if (wrEn && wrAddr == rdAddr) begin
      rdData_d = wrData;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // every level comes out of reset at the lowest programmable value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < PRIO_DEPTH; i++) begin
        mem_q[i] <= PRIO_RESET;
      end
      rdData_q <= PRIO_RESET;
    end else begin
      if (wrEn) begin
        mem_q[wrAddr] <= wrData;
      end
      rdData_q <= rdData_d;
    end
  end

endmodule // priority_store

// *** verification/core_fetch_model.sv ***
// processor core model: boot capture and vector fetch requests
module core_fetch_model
  import vector_table_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             reqGo,
  input  wire logic [VEC_W-1:0] reqVec,
  input  wire logic             bootBusy_q,
  input  wire vecAnswer_s       ans_q,
  output      logic             fetchReq,
  output      logic [VEC_W-1:0] fetchVec,
  output      vecAnswer_s       lastAns,
  output      vecAnswer_s       bootAns0,
  output      vecAnswer_s       bootAns1,
  output      logic [15:0]      ansCount
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // fetch requests and answer log
  // ----------------------------------------------------------------
  // one-cycle fetch pulse, held off until the boot pair is out
  initial begin
    fetchReq = 1'b0;
    fetchVec = 7'h00;
    forever begin
      @(posedge clk);
      if (reqGo === 1'b1) begin
        while (bootBusy_q !== 1'b0) @(posedge clk);
        #2 fetchReq = 1'b1;
        fetchVec = reqVec;
        @(posedge clk);
        #2 fetchReq = 1'b0;
        fetchVec = ~reqVec; // released lines must not keep the vector
      end
    end
  end

  // first two answers after reset are the stack and reset slots
  initial begin
    ansCount = 16'h0000;
    lastAns  = '0;
    bootAns0 = '0;
    bootAns1 = '0;
    forever begin
      @(posedge clk);
      #1;
      if (sys_rst === 1'b1) begin
        ansCount = 16'h0000;
      end else if (ans_q.valid === 1'b1) begin
        if (ansCount == 16'h0000) bootAns0 = ans_q;
        if (ansCount == 16'h0001) bootAns1 = ans_q;
        lastAns  = ans_q;
        ansCount = ansCount + 16'h0001;
      end
    end
  end
endmodule // core_fetch_model

// *** verification/tb_exception_vector_table.sv ***
// self-checking bench for the exception vector table
module tb_exception_vector_table
  import vector_table_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk, sys_rst, reqGo, fetchReq;
  logic [VEC_W-1:0]  reqVec, fetchVec;
  baseWr_s           baseWr;
  prioWr_s           prioWr;
  nmiSrc_s           nmiSrc, nmiCause_q;
  busErr_s           busErr;
  vecAnswer_s        ans_q, lastAns, bootAns0, bootAns1;
  logic              bootBusy_q, baseWrErr_q, nmiReq_q, busFaultReq_q, busFaultPrecise_q;
  logic [ADDR_W-1:0] vecBase_q;
  logic [15:0]       ansCount;
  int                fails = 0;
  int                compares = 0;

  exception_vector_table i_exception_vector_table (
    .clk(clk), .sys_rst(sys_rst), .fetchReq(fetchReq), .fetchVec(fetchVec),
    .baseWr(baseWr), .prioWr(prioWr), .nmiSrc(nmiSrc), .busErr(busErr),
    .ans_q(ans_q), .bootBusy_q(bootBusy_q), .vecBase_q(vecBase_q),
    .baseWrErr_q(baseWrErr_q), .nmiReq_q(nmiReq_q), .nmiCause_q(nmiCause_q),
    .busFaultReq_q(busFaultReq_q), .busFaultPrecise_q(busFaultPrecise_q));

  core_fetch_model i_core_fetch_model (
    .clk(clk), .sys_rst(sys_rst), .reqGo(reqGo), .reqVec(reqVec),
    .bootBusy_q(bootBusy_q), .ans_q(ans_q), .fetchReq(fetchReq), .fetchVec(fetchVec),
    .lastAns(lastAns), .bootAns0(bootAns0), .bootAns1(bootAns1), .ansCount(ansCount));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // reset held three edges, then wait for the boot pair to be logged
  task automatic do_reset();
    int n;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #2 sys_rst = 1'b0;
    n = 0;
    while (bootBusy_q !== 1'b0 && n < 20) begin
      @(posedge clk);
      #2;
      n++;
    end
    check("bootBusy_q", bootBusy_q, 1'b0);
    repeat (2) @(posedge clk);
    #2;
  endtask

  task automatic lookup(input logic [VEC_W-1:0] v);
    logic [15:0] c0;
    int n;
    c0 = ansCount;
    reqVec = v;
    reqGo = 1'b1;
    @(posedge clk);
    #2 reqGo = 1'b0;
    n = 0;
    while (ansCount == c0 && n < 20) begin
      @(posedge clk);
      #2;
      n++;
    end
    check("answer arrived", ansCount != c0, 1'b1);
    // answer strobe stands one cycle only; a stuck valid would double-count
    @(posedge clk);
    #2;
    check("ans_q.valid", ans_q.valid, 1'b0);
  endtask

  function automatic logic [FPRI_W-1:0] expPrio(input logic [VEC_W-1:0] v,
                                                input logic [7:0] lvl);
    case (v)
      7'h00:   return 9'h000;
      7'h01:   return 9'h1fd;
      7'h02:   return 9'h1fe;
      7'h03:   return 9'h1ff;
      default: return {1'b0, lvl};
    endcase
  endfunction

  task automatic checkSlot(input logic [VEC_W-1:0] v, input logic [31:0] base,
                           input logic [7:0] lvl);
    logic rsv;
    logic fix;
    rsv = (v >= 7'h07 && v <= 7'h0a) || v == 7'h0d || v > 7'h6b;
    fix = v >= 7'h01 && v <= 7'h03;
    lookup(v);
    check("ans.vec", lastAns.vec, v);
    check("ans.addr", lastAns.addr, base + {23'h0, v, 2'b00});
    check("ans.reserved", lastAns.reserved, rsv);
    check("ans.fixed", lastAns.fixed, fix);
    check("ans.prio", lastAns.prio, expPrio(v, rsv ? 8'h00 : lvl));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    check("boot0.vec", bootAns0.vec, 7'h00);
    check("boot0.addr", bootAns0.addr, 32'h0000_0000);
    check("boot1.vec", bootAns1.vec, 7'h01);
    check("boot1.prio", bootAns1.prio, 9'h1fd);
    check("vecBase_q", vecBase_q, 32'h0000_0000);
  endtask

  // system slots 1..15, the first irqs, the last slot and the first vector past the end
  task automatic t_slots();
    for (int v = 1; v < 20; v++) checkSlot(v[6:0], 32'h0, 8'h00);
    checkSlot(7'h6b, 32'h0, 8'h00);
    checkSlot(7'h6c, 32'h0, 8'h00);
  endtask

  // writes held back to back; refusals leave the base alone
  task automatic t_reloc();
    logic        pv [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [31:0] bs [7] = '{32'h200, 32'h400, 32'h300, 32'h3fff_fe00,
                            32'h4000_0000, 32'h0, 32'h800};
    logic        ok [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] prev;
    for (int i = 0; i < 7; i++) begin
      prev = vecBase_q;
      baseWr = '{en: 1'b1, priv: pv[i], base: bs[i]};
      @(posedge clk);
      #2;
      check("baseWrErr_q", baseWrErr_q, !ok[i]);
      check("vecBase_q", vecBase_q, ok[i] ? bs[i] : prev);
    end
    baseWr.en = 1'b0;
    checkSlot(7'h10, 32'h800, 8'h00);
    checkSlot(7'h05, 32'h800, 8'h00);
    do_reset();
    check("vecBase_q", vecBase_q, 32'h0);
    check("boot0.addr", bootAns0.addr, 32'h0);
  endtask

  // fixed and reserved slots must drop priority writes
  task automatic t_prio();
    logic [VEC_W-1:0] vs [4] = '{7'd20, 7'd3, 7'd8, 7'd4};
    logic [7:0]       ls [4] = '{8'h5a, 8'h11, 8'h22, 8'hff};
    for (int i = 0; i < 4; i++) begin
      prioWr = '{en: 1'b1, vec: vs[i], level: ls[i]};
      @(posedge clk);
      #2;
    end
    prioWr.en = 1'b0;
    checkSlot(7'd20, 32'h0, 8'h5a);
    checkSlot(7'd3, 32'h0, 8'h00);
    checkSlot(7'd8, 32'h0, 8'h00);
    checkSlot(7'd4, 32'h0, 8'hff);
    do_reset();
    checkSlot(7'd20, 32'h0, 8'h00);
    checkSlot(7'd4, 32'h0, 8'h00);
  endtask

  task automatic t_nmi();
    for (int i = 0; i < 4; i++) begin
      nmiSrc = nmiSrc_s'(4'h1 << i);
      @(posedge clk);
      #2;
      check("nmiReq_q", nmiReq_q, 1'b1);
      check("nmiCause_q", nmiCause_q, 4'h1 << i);
      nmiSrc = '0;
      @(posedge clk);
      #2;
      check("nmiReq_q", nmiReq_q, 1'b0);
    end
  endtask

  // every mix of the three error bits and the precise flag;
  // precise flag alone must not raise a fault
  task automatic t_bus();
    for (int i = 0; i < 16; i++) begin
      busErr = busErr_s'(i[3:0]);
      @(posedge clk);
      #2;
      check("busFaultReq_q", busFaultReq_q, i[3:1] != 3'b000);
      check("busFaultPrecise_q", busFaultPrecise_q, i[3:1] != 3'b000 && i[0]);
    end
    busErr = '0;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // whole run is well under a thousand cycles
  initial begin
    #(25 * 5000);
    fails++;
    print_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    reqGo   = 1'b0;
    reqVec  = 7'h00;
    baseWr  = '0;
    prioWr  = '0;
    nmiSrc  = '0;
    busErr  = '0;
    #2;
    do_reset();
    t_boot();
    t_slots();
    t_reloc();
    t_prio();
    t_nmi();
    t_bus();
    print_verdict();
  end
endmodule // tb_exception_vector_table
